// file: bench/cdcr_regs_bench.sv
// bench: serial frames against the configuration outputs
`timescale 1ns/1ps
`default_nettype none
module cdcr_regs_bench
	import cdcr_pkg::*;
;
	localparam cdcr_cfg_s RV = '{1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 4'h8, 4'h1, 1'b0, 1'b0};
	logic      core_clk = 1'b0;
	logic      rst_b    = 1'b0;
	logic      sclk     = 1'b1;
	logic      csb_b    = 1'b1;
	logic      sdi      = 1'b0;
	logic      sdo;
	logic      sdo_oe;
	cdcr_cfg_s cfg;
	cdcr_ups_s ups;
	cdcr_cfg_s e;
	logic [7:0] q;
	logic      oe;
	int        n_fail     = 0;
	int        num_checks = 0;
	int        cyc        = 0;
	cdcr_regs cdcr_regs_inst (.core_clk(core_clk), .rst_b(rst_b), .sclk(sclk), .csb_b(csb_b),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .cfg(cfg), .ups(ups));
	always #20 core_clk = ~core_clk;
	// hang guard: about three times the expected run
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			end_of_test();
		end
	end
	// ****
	// helpers
	// ****
	task cmp(input string n, input logic [15:0] x, input logic [15:0] g);
		num_checks++;
		if (g !== x) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask : cmp
	// phases of six clocks keep clear of the two-flop pin sampling
	task xfer(input logic r, input logic [14:0] a, input logic [7:0] d);
		logic [23:0] f;
		f = {r, a, d};
		csb_b <= 1'b0;
		repeat (6) @(posedge core_clk);
		for (int i = 23; i >= 0; i--) begin
			sclk <= 1'b0;
			sdi <= f[i];
			repeat (6) @(posedge core_clk);
			if (i < 8) q[i] = sdo;
			if (i == 0) oe = sdo_oe;
			sclk <= 1'b1;
			repeat (6) @(posedge core_clk);
		end
		csb_b <= 1'b1;
		repeat (8) @(posedge core_clk);
	endtask : xfer
	task wr(input logic [14:0] a, input logic [7:0] d);
		xfer(1'b0, a, d);
		cmp("cfg", e, cfg);
		cmp("sdo_oe", 16'h0000, oe);
	endtask : wr
	task rd(input logic [14:0] a, input logic [7:0] x);
		xfer(1'b1, a, 8'h00);
		cmp("read data", x, q);
		cmp("sdo_oe", 16'h0001, oe);
		cmp("sdo_oe idle", 16'h0000, sdo_oe);
	endtask : rd
	// ****
	// scenarios
	// ****
	task t_reset;
		e = RV;
		cmp("cfg", e, cfg);
		cmp("ups", 3'b001, ups);
		rd(CDCR_ADDR_CLK_POL, 8'h03);
		rd(CDCR_ADDR_TEST_OUT, 8'h00);
		rd(CDCR_ADDR_LANE_UPS, 8'h81);
		rd(CDCR_ADDR_SIG_PATH, 8'h00);
	endtask : t_reset
	task t_clock;
		e.core_clock_flip = 1'b1;
		wr(CDCR_ADDR_CLK_POL, 8'hff);
		rd(CDCR_ADDR_CLK_POL, 8'h07);
		e.duty_correction_on = 1'b0;
		e.cross_control_on = 1'b0;
		wr(CDCR_ADDR_CLK_POL, 8'h04);
	endtask : t_clock
	task t_test_out;
		e.test_clk_on = 1'b1;
		e.test_clk_div = 2'h3;
		wr(CDCR_ADDR_TEST_OUT, 8'hff);
		rd(CDCR_ADDR_TEST_OUT, 8'h83);
		e.test_clk_on = 1'b0;
		e.test_clk_div = 2'h2;
		wr(CDCR_ADDR_TEST_OUT, 8'h02);
	endtask : t_test_out
	// every code up to the reset lane count, reserved ones included
	task t_upsample;
		for (int c = 0; c <= 8; c++) begin
			e.serial_lane_count = 4'(c);
			e.upsample_factor = 4'(c);
			wr(CDCR_ADDR_LANE_UPS, {4'(c), 4'(c)});
			cmp("ups", {c == 6, c == 7, c <= 2}, ups);
		end
		rd(CDCR_ADDR_LANE_UPS, 8'h88);
	endtask : t_upsample
	task t_path;
		e.sinc_compensation_on = 1'b1;
		e.modulation_on = 1'b1;
		wr(CDCR_ADDR_SIG_PATH, 8'hff);
		rd(CDCR_ADDR_SIG_PATH, 8'hc0);
		e.sinc_compensation_on = 1'b0;
		wr(CDCR_ADDR_SIG_PATH, 8'h40);
	endtask : t_path
	task t_unmapped;
		wr(15'h0200, 8'hff);
		rd(15'h0200, CDCR_READ_ZERO);
	endtask : t_unmapped
	task end_of_test;
		if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_reset();
		t_clock();
		t_test_out();
		t_upsample();
		t_path();
		t_unmapped();
		// second reset in mid-run must restore every field
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_reset();
		end_of_test();
	end
endmodule : cdcr_regs_bench
bind cdcr_regs cdcr_regs_monitor cdcr_regs_monitor_inst (.core_clk(core_clk), .rst_b(rst_b),
	.csb_b(csb_b), .cfg(cfg), .ups(ups));
`default_nettype wire

// file: bench/cdcr_regs_monitor.sv
// checker: reset values, upsample decode and quiet controls outside frames
`timescale 1ns/1ps
`default_nettype none
module cdcr_regs_monitor
	import cdcr_pkg::*;
(
	input wire logic      core_clk, // system clock
	input wire logic      rst_b,    // sync reset, active low
	input wire logic      csb_b,    // chip select pin
	input wire cdcr_cfg_s cfg,      // static controls
	input wire cdcr_ups_s ups       // upsample decode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ****
	// properties
	// ****
	// frame long gone: synchroniser and write pipe are empty by now
	sequence deselected;
		csb_b[*6];
	endsequence
	a_rst_clock_bits: assert property ($rose(rst_b) |->
		{cfg.core_clock_flip, cfg.duty_correction_on, cfg.cross_control_on} == 3'b011)
		else $error("clock bits wrong after reset");
	a_rst_test_out: assert property ($rose(rst_b) |->
		!cfg.test_clk_on && cfg.test_clk_div == 2'h0) else $error("test output not off");
	a_rst_data_path: assert property ($rose(rst_b) |->
		cfg.serial_lane_count == 4'h8 && cfg.upsample_factor == 4'h1
		&& !cfg.sinc_compensation_on && !cfg.modulation_on) else $error("datapath reset wrong");
	a_x12_decode: assert property ($past(rst_b) |->
		ups.x12 == ($past(cfg.upsample_factor) == 4'h6)) else $error("x12 decode wrong");
	a_x16_decode: assert property ($past(rst_b) |->
		ups.x16 == ($past(cfg.upsample_factor) == 4'h7)) else $error("x16 decode wrong");
	a_reserved_code_flag: assert property ($past(rst_b) |->
		ups.reserved == ($past(cfg.upsample_factor) <= 4'h2)) else $error("reserved flag wrong");
	a_cfg_needs_frame: assert property ($past(rst_b) && $changed(cfg) |-> !$past(csb_b, 5))
		else $error("controls moved without a frame");
	a_cfg_idle_quiet: assert property (deselected ##0 $past(rst_b) |-> $stable(cfg))
		else $error("controls moved while deselected");
endmodule : cdcr_regs_monitor
`default_nettype wire

// file: design/cdcr_pkg.sv
// package: register map, field layout, reset values and serial framing constants
package cdcr_pkg;

	// ****************************************************************
	// register offsets on the configuration serial port
	// ****************************************************************
	localparam logic [14:0] CDCR_ADDR_CLK_POL  = 15'h009d; // digital_clock_polarity_ctrl
	localparam logic [14:0] CDCR_ADDR_TEST_OUT = 15'h00a0; // loop_clock_test_output
	localparam logic [14:0] CDCR_ADDR_LANE_UPS = 15'h0110; // lane_and_upsample_select
	localparam logic [14:0] CDCR_ADDR_SIG_PATH = 15'h0111; // signal_path_setup

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CDCR_POS_FLIP      = 2;
	localparam int CDCR_POS_DUTY      = 1;
	localparam int CDCR_POS_CROSS     = 0;
	localparam int CDCR_POS_TEST_EN   = 7;
	localparam int CDCR_POS_DIV_HI    = 1;
	localparam int CDCR_POS_DIV_LO    = 0;
	localparam int CDCR_POS_LANE_HI   = 7;
	localparam int CDCR_POS_LANE_LO   = 4;
	localparam int CDCR_POS_UPS_HI    = 3;
	localparam int CDCR_POS_UPS_LO    = 0;
	localparam int CDCR_POS_SINC      = 7;
	localparam int CDCR_POS_MOD       = 6;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic       CDCR_RST_FLIP  = 1'h0;
	localparam logic       CDCR_RST_DUTY  = 1'h1;
	localparam logic       CDCR_RST_CROSS = 1'h1;
	localparam logic       CDCR_RST_TEST  = 1'h0;
	localparam logic [1:0] CDCR_RST_DIV   = 2'h0;
	localparam logic [3:0] CDCR_RST_LANES = 4'h8;
	localparam logic [3:0] CDCR_RST_UPS   = 4'h1;
	localparam logic       CDCR_RST_SINC  = 1'h0;
	localparam logic       CDCR_RST_MOD   = 1'h0;

	// ****************************************************************
	// upsample codes
	// ****************************************************************
	localparam logic [3:0] CDCR_UPS_X12     = 4'h6;
	localparam logic [3:0] CDCR_UPS_X16     = 4'h7;
	localparam logic [3:0] CDCR_UPS_LOW_RSV = 4'h2; // codes up to this one are reserved

	// ****************************************************************
	// serial framing: 16 instruction bits then 8 data bits
	// ****************************************************************
	localparam logic [4:0] CDCR_INSTR_BITS = 5'h10;
	localparam logic [4:0] CDCR_FRAME_BITS = 5'h18;
	localparam logic [7:0] CDCR_READ_ZERO  = 8'h00;

	// static controls handed to the clock and datapath logic
	typedef struct packed {
		logic       core_clock_flip;
		logic       duty_correction_on;
		logic       cross_control_on;
		logic       test_clk_on;
		logic [1:0] test_clk_div;
		logic [3:0] serial_lane_count;
		logic [3:0] upsample_factor;
		logic       sinc_compensation_on;
		logic       modulation_on;
	} cdcr_cfg_s;

	// decoded upsample selection
	typedef struct packed {
		logic x12;
		logic x16;
		logic reserved;
	} cdcr_ups_s;

endpackage : cdcr_pkg

// file: design/cdcr_regs.sv
// module: clock and datapath configuration registers behind the serial port
`timescale 1ns/1ps
`default_nettype none
module cdcr_regs
	import cdcr_pkg::*;
(
	input  wire logic core_clk,    // system clock, 25 MHz
	input  wire logic rst_b,       // synchronous reset, active low
	input  wire logic sclk,        // serial port clock pin
	input  wire logic csb_b,       // serial port chip select pin, active low
	input  wire logic sdi,         // serial data in pin
	output var  logic sdo,         // serial data out
	output var  logic sdo_oe,      // sdo output enable, high while driven
	output var  cdcr_cfg_s cfg,    // static clock and datapath controls
	output var  cdcr_ups_s ups     // decoded upsample selection
);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	// the serial pins are oversampled on core_clk rather than clocked by sclk,
	// so every sclk phase must last at least four core clocks; a faster host
	// loses edges silently, which was traded for a single clock domain
	logic       sclk_m_q, sclk_s_q, sclk_p_q;
	logic       csb_m_q, csb_s_q;
	logic       sdi_m_q, sdi_s_q;

	// two flops per pin, plus a third on sclk for edge detection; the first stage is never looked at
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			sclk_m_q <= 1'b0;
			sclk_s_q <= 1'b0;
			sclk_p_q <= 1'b0;
			csb_m_q  <= 1'b1;
			csb_s_q  <= 1'b1;
			sdi_m_q  <= 1'b0;
			sdi_s_q  <= 1'b0;
		end else begin
			sclk_m_q <= sclk;
			sclk_s_q <= sclk_m_q;
			sclk_p_q <= sclk_s_q;
			csb_m_q  <= csb_b;
			csb_s_q  <= csb_m_q;
			sdi_m_q  <= sdi;
			sdi_s_q  <= sdi_m_q;
		end
	end

	// edge detection on the synchronised serial clock
	// after reset a high idle sclk shows one false rise; it is harmless
	// because the bit counter is held clear until chip select is seen low
	wire sclk_rise = sclk_s_q & ~sclk_p_q;
	wire sclk_fall = ~sclk_s_q & sclk_p_q;
	wire active    = ~csb_s_q;

	// ****************************************************************
	// serial frame tracking
	// ****************************************************************
	// frame: one direction bit (high reads), a 15-bit offset, then one data
	// byte, most significant bit first; bits past the byte are ignored, so
	// there is no address auto-increment and no multi-byte transfer
	logic [4:0]  bit_cnt_q;
	logic [22:0] shift_q;
	logic        rd_q;
	logic [14:0] addr_q;
	logic [7:0]  rd_sh_q;
	logic        sdo_q, sdo_oe_q;

	// frame words as seen on the current rising edge
	wire [4:0]  bit_cnt_d  = bit_cnt_q + 5'h01;
	wire [15:0] instr_word = {shift_q[14:0], sdi_s_q};
	wire [7:0]  data_word  = {shift_q[6:0], sdi_s_q};
	wire        instr_done = active & sclk_rise & (bit_cnt_d == CDCR_INSTR_BITS);
	wire        frame_done = active & sclk_rise & (bit_cnt_d == CDCR_FRAME_BITS);
	wire        in_data    = (bit_cnt_q >= CDCR_INSTR_BITS) & (bit_cnt_q < CDCR_FRAME_BITS);
	wire        wr_stb     = frame_done & ~rd_q;

	// write strobes per register
	// unmapped offsets match none of them, so such writes fall away
	wire wr_pol  = wr_stb & (addr_q == CDCR_ADDR_CLK_POL);
	wire wr_test = wr_stb & (addr_q == CDCR_ADDR_TEST_OUT);
	wire wr_lane = wr_stb & (addr_q == CDCR_ADDR_LANE_UPS);
	wire wr_path = wr_stb & (addr_q == CDCR_ADDR_SIG_PATH);

	// bit counter and input shift; a raised chip select aborts the frame
	always_ff @(posedge core_clk) begin
		if (!rst_b || !active) begin
			bit_cnt_q <= 5'h00;
			shift_q   <= 23'h000000;
		end else if (sclk_rise && bit_cnt_q < CDCR_FRAME_BITS) begin
			bit_cnt_q <= bit_cnt_d;
			shift_q   <= {shift_q[21:0], sdi_s_q};
		end
	end

	// latch direction and address once the instruction is complete
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rd_q   <= 1'b0;
			addr_q <= 15'h0000;
		end else if (instr_done) begin
			rd_q   <= instr_word[15];
			addr_q <= instr_word[14:0];
		end
	end

	// ****************************************************************
	// read data path
	// ****************************************************************
	// the offset comes from the live instruction word, not addr_q, because
	// addr_q only settles on the same edge that loads the read shifter
	logic [7:0] rd_data;

	// reserved bits and unmapped offsets read as zero
	wire [7:0] rd_pol  = {5'h00, cfg.core_clock_flip, cfg.duty_correction_on,
		cfg.cross_control_on};
	wire [7:0] rd_test = {cfg.test_clk_on, 5'h00, cfg.test_clk_div};
	wire [7:0] rd_lane = {cfg.serial_lane_count, cfg.upsample_factor};
	wire [7:0] rd_path = {cfg.sinc_compensation_on, cfg.modulation_on, 6'h00};
	wire [14:0] rd_addr = instr_word[14:0];

	// address is taken straight from the instruction so data is ready in time
	always_comb begin
		rd_data = CDCR_READ_ZERO;
		unique case (rd_addr)
			CDCR_ADDR_CLK_POL:  rd_data = rd_pol;
			CDCR_ADDR_TEST_OUT: rd_data = rd_test;
			CDCR_ADDR_LANE_UPS: rd_data = rd_lane;
			CDCR_ADDR_SIG_PATH: rd_data = rd_path;
			default:            rd_data = CDCR_READ_ZERO;
		endcase
	end

	// read shifter: loaded after the instruction, one bit per falling edge
	// sdo moves on the falling edge so the host samples a settled bit
	// on the following rising edge
	always_ff @(posedge core_clk) begin
		if (!rst_b || !active) begin
			rd_sh_q  <= 8'h00;
			sdo_q    <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else if (instr_done) begin
			rd_sh_q  <= rd_data;
			sdo_oe_q <= instr_word[15];
		end else if (sclk_fall && rd_q && in_data) begin
			sdo_q   <= rd_sh_q[7];
			rd_sh_q <= {rd_sh_q[6:0], 1'b0};
		end
	end

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	// lanes and upsample apply at once; holding the deframer in reset is up to software
	// gating them here would need the deframer reset bit, which lives in
	// another block, so the ordering stays a software duty
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cfg.core_clock_flip      <= CDCR_RST_FLIP;
			cfg.duty_correction_on   <= CDCR_RST_DUTY;
			cfg.cross_control_on     <= CDCR_RST_CROSS;
			cfg.test_clk_on          <= CDCR_RST_TEST;
			cfg.test_clk_div         <= CDCR_RST_DIV;
			cfg.serial_lane_count    <= CDCR_RST_LANES;
			cfg.upsample_factor      <= CDCR_RST_UPS;
			cfg.sinc_compensation_on <= CDCR_RST_SINC;
			cfg.modulation_on        <= CDCR_RST_MOD;
		end else begin
			if (wr_pol) begin
				cfg.core_clock_flip    <= data_word[CDCR_POS_FLIP];
				cfg.duty_correction_on <= data_word[CDCR_POS_DUTY];
				cfg.cross_control_on   <= data_word[CDCR_POS_CROSS];
			end
			if (wr_test) begin
				cfg.test_clk_on  <= data_word[CDCR_POS_TEST_EN];
				cfg.test_clk_div <= data_word[CDCR_POS_DIV_HI:CDCR_POS_DIV_LO];
			end
			if (wr_lane) begin
				cfg.serial_lane_count <= data_word[CDCR_POS_LANE_HI:CDCR_POS_LANE_LO];
				cfg.upsample_factor   <= data_word[CDCR_POS_UPS_HI:CDCR_POS_UPS_LO];
			end
			if (wr_path) begin
				cfg.sinc_compensation_on <= data_word[CDCR_POS_SINC];
				cfg.modulation_on        <= data_word[CDCR_POS_MOD];
			end
		end
	end

	// ****************************************************************
	// upsample decode
	// ****************************************************************
	// flags lag the stored field by one cycle; reserved codes are only flagged
	// the low codes, the reset code included, count as reserved; they are
	// stored as written so a read shows what software actually put there
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ups <= '0;
		end else begin
			ups.x12      <= (cfg.upsample_factor == CDCR_UPS_X12);
			ups.x16      <= (cfg.upsample_factor == CDCR_UPS_X16);
			ups.reserved <= (cfg.upsample_factor <= CDCR_UPS_LOW_RSV);
		end
	end

	// pins are fed straight from their flops, no logic after the last stage
	assign sdo    = sdo_q;
	assign sdo_oe = sdo_oe_q;

endmodule : cdcr_regs
`default_nettype wire
